// >>> hw/dsc_params.svh
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH

// register offset, same in sequencer and device space
`define DSC_CMD0_OFFSET 8'h84

// field positions
`define DSC_BIT_CACHE_TH 3'd7
`define DSC_BIT_DPAR_EN 3'd6
`define DSC_BIT_MPAR_EN 3'd5
`define DSC_BIT_REQ_LOCK 3'd4
`define DSC_BIT_INT_RAM 3'd3
`define DSC_BIT_RAM_PRES 3'd2
`define DSC_BIT_PAGE32 3'd1
`define DSC_BIT_CIO_EN 3'd0

// reset value with the ram present bit taken as zero
`define DSC_CMD0_RESET 8'h08
// bits that software may write
`define DSC_CMD0_WMASK 8'hFB
// bits restored by a chip reset write
`define DSC_CMD0_CRMASK 8'hFA

`endif

// >>> hw/dsc_pkg.sv
`default_nettype none
package dsc_pkg;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dsc_req_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic par;
	} dsc_beat_t;

	typedef struct packed {
		logic cache_threshold_enable;
		logic data_parity_check_enable;
		logic memory_parity_check_enable;
		logic external_request_lock;
		logic internal_block_ram_select;
		logic ram_present_status;
		logic small_block_page_select;
		logic internal_bus_parity_check_enable;
	} dsc_cmd0_t;

endpackage
`default_nettype wire

// >>> hw/dsc_cmd0.sv
//
// Contract
// - both spaces reach register 84h without pausing
// - bits 7:3,1 change by write, chip reset, reset
// - cache threshold times bus requests from threshold
// - cache-line sized bursts with cache-line commands
// - flushed last write transfer goes even partial
// - data parity enable low skips data checks
// - scsi pio read parity follows scsi mode control
// - data parity error sets break status, interrupt, and off scsi pio its own flag
// - memory parity enable low skips memory checks
// - odd memory parity errors set flags, interrupt
// - odd memory write parity always generated
// - request lock holds arbitration request asserted
// - ram select picks internal or external ram
// - chip reset write forces internal ram select
// - ram present status inverts sampled pin
// - page select: 1 is 32 bytes, 0 is 64
// - internal bus parity errors gated by bit 0
`timescale 1ns/1ps
`default_nettype none
`include "dsc_params.svh"

module dsc_cmd0 (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// register access, sequencer space and device space
	input wire dsc_pkg::dsc_req_t seq_req,
	output logic [7:0] seq_rdata,
	output logic seq_rd_hit,
	input wire dsc_pkg::dsc_req_t dev_req,
	output logic [7:0] dev_rdata,
	output logic dev_rd_hit,
	input wire logic chip_reset_control,
	// pins
	input wire logic ram_present_pin_n,
	output logic external_arbitration_request_n,
	output logic interrupt_request_output_n,
	// bus master
	input wire logic [7:0] fifo_level,
	input wire logic [7:0] fifo_threshold_setting,
	input wire logic [7:0] latency_timer_value,
	input wire logic [7:0] cache_line_size_value,
	input wire logic fifo_flush_indication,
	input wire logic write_to_memory,
	output logic master_request,
	output logic [7:0] master_burst_len,
	output logic master_cache_cmd,
	// data path parity
	input wire dsc_pkg::dsc_beat_t data_beat,
	input wire logic data_is_scsi_pio,
	input wire logic scsi_mode_control_one,
	output logic data_parity_error_flag,
	// memory parity
	input wire dsc_pkg::dsc_beat_t mem_rd_beat,
	input wire logic mem_rd_external,
	input wire logic external_block_parity_enable,
	input wire logic mem_wr_valid,
	input wire logic [7:0] mem_wr_data,
	output logic [7:0] mem_wr_data_out,
	output logic mem_wr_par_out,
	output logic memory_parity_error_flag,
	// interrupt reporting
	output logic break_address_interrupt_status,
	input wire logic break_address_clear,
	input wire logic interrupt_enable_bit,
	input wire logic power_down_bit,
	// internal bus parity
	input wire logic internal_bus_parity_error,
	output logic internal_bus_parity_error_flag,
	// ram configuration
	output logic use_internal_block_ram,
	output logic small_block_page_select
);
	import dsc_pkg::*;

	function automatic logic odd_bad(input logic [7:0] d, input logic p);
		odd_bad = ~^{d, p};
	endfunction

	// pin synchroniser
	logic ramp_s1_q, ramp_s1_d;
	logic ramp_s2_q, ramp_s2_d;

	// register and outputs
	dsc_cmd0_t cmd_q, cmd_d;
	logic [7:0] seq_rdata_q, seq_rdata_d;
	logic [7:0] dev_rdata_q, dev_rdata_d;
	logic seq_hit_q, seq_hit_d;
	logic dev_hit_q, dev_hit_d;
	logic arb_q, arb_d;
	logic req_q, req_d;
	logic [7:0] burst_q, burst_d;
	logic ccmd_q, ccmd_d;
	logic dperr_q, dperr_d;
	logic mperr_q, mperr_d;
	logic cioerr_q, cioerr_d;
	logic brk_q, brk_d;
	logic irq_q, irq_d;
	logic [7:0] wdat_q, wdat_d;
	logic wpar_q, wpar_d;

	logic seq_wr_hit, dev_wr_hit;
	logic dchk, dbad, mchk, mbad, partial;

	always_comb begin
		ramp_s1_d = ram_present_pin_n;
		ramp_s2_d = ramp_s1_q;

		// both spaces decode the same offset; device space wins a same-cycle clash
		seq_wr_hit = seq_req.wr && seq_req.addr == `DSC_CMD0_OFFSET;
		dev_wr_hit = dev_req.wr && dev_req.addr == `DSC_CMD0_OFFSET;
		cmd_d = cmd_q;
		if (seq_wr_hit) begin
			cmd_d = (cmd_q & ~`DSC_CMD0_WMASK) | (seq_req.wdata & `DSC_CMD0_WMASK);
		end
		if (dev_wr_hit) begin
			cmd_d = (cmd_q & ~`DSC_CMD0_WMASK) | (dev_req.wdata & `DSC_CMD0_WMASK);
		end
		// chip reset beats a register write issued in the same cycle on every bit but bits 2 and 0; bit 0 keeps the written value, bit 2 its strap
		if (chip_reset_control) begin
			cmd_d = (cmd_d & ~`DSC_CMD0_CRMASK) | (`DSC_CMD0_RESET & `DSC_CMD0_CRMASK);
			cmd_d.internal_block_ram_select = 1'b1;
		end

		seq_hit_d = seq_req.rd && seq_req.addr == `DSC_CMD0_OFFSET;
		dev_hit_d = dev_req.rd && dev_req.addr == `DSC_CMD0_OFFSET;
		seq_rdata_d = seq_hit_d ? cmd_q : 8'h00;
		dev_rdata_d = dev_hit_d ? cmd_q : 8'h00;

		// lock keeps an asserted request up; new requests still come from the registered master_request
		arb_d = master_request || (cmd_q.external_request_lock && arb_q);

		// bus master request timing
		partial = fifo_flush_indication && write_to_memory;
		if (cmd_q.cache_threshold_enable) begin
			req_d = fifo_level >= fifo_threshold_setting || (partial && fifo_level != 8'h00);
			ccmd_d = latency_timer_value != 8'h00 && cache_line_size_value != 8'h00
				&& fifo_level >= cache_line_size_value;
			burst_d = ccmd_d ? cache_line_size_value : fifo_level;
		end else begin
			req_d = fifo_level != 8'h00;
			ccmd_d = 1'b0;
			burst_d = fifo_level;
		end

		// pio reads from the scsi bus are judged by the scsi control, not this register
		dchk = data_is_scsi_pio ? scsi_mode_control_one : cmd_q.data_parity_check_enable;
		dbad = data_beat.valid && dchk && odd_bad(data_beat.data, data_beat.par);
		mchk = cmd_q.memory_parity_check_enable
			&& (!mem_rd_external || external_block_parity_enable);
		mbad = mem_rd_beat.valid && mchk && odd_bad(mem_rd_beat.data, mem_rd_beat.par);
		dperr_d = dbad && !data_is_scsi_pio;
		mperr_d = mbad;
		cioerr_d = internal_bus_parity_error && cmd_q.internal_bus_parity_check_enable;

		// break status is sticky; a new error wins over a clear in the same cycle
		brk_d = dbad || mbad || (brk_q && !break_address_clear);
		irq_d = brk_d && interrupt_enable_bit && !power_down_bit;

		// write parity does not depend on the check enable
		wdat_d = mem_wr_valid ? mem_wr_data : wdat_q;
		wpar_d = mem_wr_valid ? ~^mem_wr_data : wpar_q;
	end

	always_ff @(posedge ref_clk) begin
		ramp_s1_q <= ramp_s1_d;
		ramp_s2_q <= ramp_s2_d;
		if (reset) begin
			cmd_q <= `DSC_CMD0_RESET;
			// strap caught on the clock while reset is held
			cmd_q.ram_present_status <= ~ramp_s2_q;
			seq_rdata_q <= 8'h00;
			dev_rdata_q <= 8'h00;
			seq_hit_q <= 1'b0;
			dev_hit_q <= 1'b0;
			arb_q <= 1'b0;
			req_q <= 1'b0;
			burst_q <= 8'h00;
			ccmd_q <= 1'b0;
			dperr_q <= 1'b0;
			mperr_q <= 1'b0;
			cioerr_q <= 1'b0;
			brk_q <= 1'b0;
			irq_q <= 1'b0;
			wdat_q <= 8'h00;
			wpar_q <= 1'b1;
		end else begin
			cmd_q <= cmd_d;
			seq_rdata_q <= seq_rdata_d;
			dev_rdata_q <= dev_rdata_d;
			seq_hit_q <= seq_hit_d;
			dev_hit_q <= dev_hit_d;
			arb_q <= arb_d;
			req_q <= req_d;
			burst_q <= burst_d;
			ccmd_q <= ccmd_d;
			dperr_q <= dperr_d;
			mperr_q <= mperr_d;
			cioerr_q <= cioerr_d;
			brk_q <= brk_d;
			irq_q <= irq_d;
			wdat_q <= wdat_d;
			wpar_q <= wpar_d;
		end
	end

	assign seq_rdata = seq_rdata_q;
	assign dev_rdata = dev_rdata_q;
	assign seq_rd_hit = seq_hit_q;
	assign dev_rd_hit = dev_hit_q;
	assign external_arbitration_request_n = ~arb_q;
	assign interrupt_request_output_n = ~irq_q;
	assign master_request = req_q;
	assign master_burst_len = burst_q;
	assign master_cache_cmd = ccmd_q;
	assign data_parity_error_flag = dperr_q;
	assign memory_parity_error_flag = mperr_q;
	assign internal_bus_parity_error_flag = cioerr_q;
	assign break_address_interrupt_status = brk_q;
	assign mem_wr_data_out = wdat_q;
	assign mem_wr_par_out = wpar_q;
	// external ram only counts when it was strapped present
	assign use_internal_block_ram = cmd_q.internal_block_ram_select
		|| !cmd_q.ram_present_status;
	assign small_block_page_select = cmd_q.small_block_page_select;

	AST_SEQ_WRITE: assert property (@(posedge ref_clk) disable iff (reset)
		seq_wr_hit && !dev_wr_hit && !chip_reset_control
		|=> (cmd_q & `DSC_CMD0_WMASK) == ($past(seq_req.wdata) & `DSC_CMD0_WMASK))
		else $error("sequencer write to command register lost");

	AST_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
		!seq_wr_hit && !dev_wr_hit && !chip_reset_control |=> $stable(cmd_q))
		else $error("command register changed without a cause");

	AST_CHIP_RESET_CONTROL: assert property (@(posedge ref_clk) disable iff (reset)
		chip_reset_control |=> cmd_q.internal_block_ram_select
		&& !cmd_q.cache_threshold_enable && !cmd_q.small_block_page_select)
		else $error("chip reset write did not restore fields");

	// checked on release only, so the unsettled strap of the first reset edges is not judged
	AST_RAM_PRESENT_PIN: assert property (@(posedge ref_clk)
		$fell(reset) |-> cmd_q.ram_present_status == !$past(ramp_s2_q))
		else $error("ram present status not inverse of strap");

	AST_DEV_WRITE: assert property (@(posedge ref_clk) disable iff (reset)
		dev_wr_hit && !chip_reset_control
		|=> (cmd_q & `DSC_CMD0_WMASK) == ($past(dev_req.wdata) & `DSC_CMD0_WMASK))
		else $error("device write to command register lost");

	AST_SEQ_READ: assert property (@(posedge ref_clk) disable iff (reset)
		seq_req.rd && seq_req.addr == `DSC_CMD0_OFFSET
		|=> seq_rd_hit && seq_rdata == $past(cmd_q))
		else $error("sequencer read of command register wrong");

	AST_RAM_SEL: assert property (@(posedge ref_clk) disable iff (reset)
		!cmd_q.ram_present_status |-> use_internal_block_ram)
		else $error("external ram selected while absent");

	AST_THRESH: assert property (@(posedge ref_clk) disable iff (reset)
		cmd_q.cache_threshold_enable && fifo_level >= fifo_threshold_setting
		|=> master_request)
		else $error("threshold reached without bus request");

	AST_FLUSH: assert property (@(posedge ref_clk) disable iff (reset)
		cmd_q.cache_threshold_enable && fifo_flush_indication && write_to_memory
		&& fifo_level != 8'h00 |=> master_request)
		else $error("flushed partial transfer not requested");

	AST_DPAR_OFF: assert property (@(posedge ref_clk) disable iff (reset)
		!data_is_scsi_pio && !cmd_q.data_parity_check_enable |=> !data_parity_error_flag)
		else $error("data parity checked while disabled");

	AST_DPAR_ON: assert property (@(posedge ref_clk) disable iff (reset)
		data_beat.valid && !data_is_scsi_pio && cmd_q.data_parity_check_enable
		&& odd_bad(data_beat.data, data_beat.par)
		|=> data_parity_error_flag && break_address_interrupt_status)
		else $error("data parity error not reported");

	AST_MPAR: assert property (@(posedge ref_clk) disable iff (reset)
		mbad |=> memory_parity_error_flag && break_address_interrupt_status)
		else $error("memory parity error not reported");

	AST_MPAR_OFF: assert property (@(posedge ref_clk) disable iff (reset)
		!cmd_q.memory_parity_check_enable |=> !memory_parity_error_flag)
		else $error("memory parity checked while disabled");

	AST_WPAR: assert property (@(posedge ref_clk) disable iff (reset)
		mem_wr_valid |=> ^{mem_wr_data_out, mem_wr_par_out} == 1'b1)
		else $error("memory write parity not odd");

	AST_LOCK: assert property (@(posedge ref_clk) disable iff (reset)
		!external_arbitration_request_n && cmd_q.external_request_lock
		|=> !external_arbitration_request_n)
		else $error("locked arbitration request dropped");

	AST_CIO: assert property (@(posedge ref_clk) disable iff (reset)
		!cmd_q.internal_bus_parity_check_enable |=> !internal_bus_parity_error_flag)
		else $error("internal bus parity flag set while disabled");

	AST_IRQ: assert property (@(posedge ref_clk) disable iff (reset)
		power_down_bit |=> interrupt_request_output_n)
		else $error("interrupt driven during power down");

	AST_CACHE: assert property (@(posedge ref_clk) disable iff (reset)
		master_cache_cmd |-> master_burst_len == $past(cache_line_size_value))
		else $error("cache command burst not one cache line");

endmodule
`default_nettype wire

// >>> dv/dsc_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsc_seq_model (
	// clock
	input wire logic ref_clk,
	// command from the bench
	input wire dsc_pkg::dsc_req_t cmd,
	// access toward the block
	output dsc_pkg::dsc_req_t req
);
	import dsc_pkg::*;
	// launched off the falling edge, so each access is one whole settled cycle
	always_ff @(negedge ref_clk) begin
		req <= cmd;
	end
endmodule
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsc_params.svh"
module tb;
	import dsc_pkg::*;
	logic ref_clk = 0, reset = 1, crc = 0, pin_n = 1, flush = 0, pio = 0, mwv = 0;
	logic bclr = 0, pdn = 0, cerr = 0, wmem = 0;
	dsc_req_t seq_cmd = '0, seq_req, dev_req = '0;
	dsc_beat_t dbeat = '0, mbeat = '0;
	logic [7:0] seq_rdata, dev_rdata, lvl = 0, thr = 0, wdat = 0, wout, blen;
	logic seq_hit, dev_hit, arb_n, irq_n, mreq, ccmd, dflag, wpar, mflag, brk, cflag, intram, page;
	logic [7:0] lat = 0, csz = 0;
	logic [7:0] exp_q[$];
	int n_errors = 0, samples_checked = 0;

	dsc_seq_model seq_u (.ref_clk(ref_clk), .cmd(seq_cmd), .req(seq_req));
	dsc_cmd0 dut_u (.ref_clk(ref_clk), .reset(reset), .seq_req(seq_req),
		.seq_rdata(seq_rdata), .seq_rd_hit(seq_hit), .dev_req(dev_req),
		.dev_rdata(dev_rdata), .dev_rd_hit(dev_hit), .chip_reset_control(crc),
		.ram_present_pin_n(pin_n), .external_arbitration_request_n(arb_n),
		.interrupt_request_output_n(irq_n), .fifo_level(lvl), .fifo_threshold_setting(thr),
		.latency_timer_value(lat), .cache_line_size_value(csz),
		.fifo_flush_indication(flush), .write_to_memory(wmem), .master_request(mreq),
		.master_burst_len(blen), .master_cache_cmd(ccmd), .data_beat(dbeat),
		.data_is_scsi_pio(pio), .scsi_mode_control_one(1'b0),
		.data_parity_error_flag(dflag), .mem_rd_beat(mbeat), .mem_rd_external(1'b0),
		.external_block_parity_enable(1'b0), .mem_wr_valid(mwv), .mem_wr_data(wdat),
		.mem_wr_data_out(wout), .mem_wr_par_out(wpar), .memory_parity_error_flag(mflag),
		.break_address_interrupt_status(brk), .break_address_clear(bclr),
		.interrupt_enable_bit(1'b1), .power_down_bit(pdn), .internal_bus_parity_error(cerr),
		.internal_bus_parity_error_flag(cflag), .use_internal_block_ram(intram),
		.small_block_page_select(page));

	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// reads note their expectation up front; the monitor pairs them in order
	task automatic acc(bit dev, bit wr, logic [7:0] a, logic [7:0] d, logic [7:0] e);
		dsc_req_t r;
		r = '{wr: wr, rd: !wr, addr: a, wdata: d};
		if (!wr && a == `DSC_CMD0_OFFSET) exp_q.push_back(e);
		@(negedge ref_clk);
		if (dev) dev_req <= r;
		else seq_cmd <= r;
		@(negedge ref_clk);
		dev_req <= '0;
		seq_cmd <= '0;
		repeat (3) @(negedge ref_clk);
	endtask

	task automatic rst(logic p);
		pin_n <= p;
		reset <= 1'b1;
		// three edges, so the pin passes both sync flops
		repeat (3) @(negedge ref_clk);
		reset <= 1'b0;
	endtask

	task automatic beat(bit mem, bit bad, logic e);
		dsc_beat_t b;
		b.valid = 1'b1;
		b.data = 8'($urandom);
		b.par = ~^b.data ^ bad;
		@(negedge ref_clk);
		if (mem) mbeat <= b;
		else dbeat <= b;
		@(negedge ref_clk);
		dbeat <= '0;
		mbeat <= '0;
		chk("parity flag", mem ? mflag : dflag, e);
		chk("break status", brk, e);
		chk("irq out", irq_n, !(e && !pdn));
		bclr <= 1'b1;
		@(negedge ref_clk);
		bclr <= 1'b0;
	endtask

	task automatic cio(logic e);
		cerr <= 1'b1;
		@(negedge ref_clk);
		cerr <= 1'b0;
		chk("cio flag", cflag, e);
	endtask

	// looked at mid-cycle, while the registered hit stands
	always @(negedge ref_clk) begin
		if (seq_hit === 1'b1 || dev_hit === 1'b1) begin
			if (exp_q.size() == 0) chk("stray read", 8'h01, 8'h00);
			else chk("read", seq_hit ? seq_rdata : dev_rdata, exp_q.pop_front());
		end
	end

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (5000) @(posedge ref_clk);
		n_errors++;
		$display("ERROR timeout");
		end_sim();
	end

	initial begin
		void'($urandom(32'h3a6e));
		rst(1'b1);
		acc(1, 0, 8'h84, 8'h00, `DSC_CMD0_RESET);
		chk("internal ram", intram, 1);
		acc(0, 1, 8'h84, 8'hFF, 8'h00);
		acc(1, 0, 8'h84, 8'h00, 8'hFB);
		chk("page", page, 1);
		acc(1, 0, 8'h85, 8'h00, 8'h00);
		crc <= 1'b1;
		@(negedge ref_clk);
		crc <= 1'b0;
		acc(0, 0, 8'h84, 8'h00, 8'h09);
		$display("test registers done");
		rst(1'b0);
		acc(1, 0, 8'h84, 8'h00, 8'h0C);
		acc(1, 1, 8'h84, 8'h00, 8'h00);
		acc(0, 0, 8'h84, 8'h00, 8'h04);
		chk("external ram", intram, 0);
		$display("test ram present done");
		acc(1, 1, 8'h84, 8'h61, 8'h00);
		for (int pd = 0; pd < 2; pd++) begin
			pdn <= pd[0];
			beat(0, 1, 1);
			beat(1, 1, 1);
			beat(0, 0, 0);
			beat(1, 0, 0);
		end
		pdn <= 1'b0;
		pio <= 1'b1;
		beat(0, 1, 0);
		pio <= 1'b0;
		cio(1);
		acc(0, 1, 8'h84, 8'h00, 8'h00);
		beat(0, 1, 0);
		beat(1, 1, 0);
		cio(0);
		mwv <= 1'b1;
		wdat <= 8'($urandom);
		@(negedge ref_clk);
		mwv <= 1'b0;
		chk("wr data", wout, wdat);
		chk("wr parity", wpar, ~^wdat);
		$display("test parity done");
		acc(1, 1, 8'h84, 8'h90, 8'h00);
		lvl <= 8'hFF;
		thr <= 8'h01;
		flush <= 1'b1;
		wmem <= 1'b1;
		repeat (3) @(negedge ref_clk);
		chk("arb req", arb_n, 0);
		chk("master req", mreq, 1);
		lvl <= 8'h00;
		flush <= 1'b0;
		repeat (4) @(negedge ref_clk);
		chk("arb held", arb_n, 0);
		// lock cleared by a sequencer write, so the held request drops
		acc(0, 1, 8'h84, 8'h00, 8'h00);
		chk("arb free", arb_n, 1);
		$display("test lock done");
		acc(1, 1, 8'h84, 8'h80, 8'h00);
		lat <= 8'h20;
		csz <= 8'h10;
		lvl <= 8'h18;
		thr <= 8'h30;
		@(negedge ref_clk);
		chk("master req", mreq, 0);
		chk("cache cmd", ccmd, 1);
		chk("burst len", blen, 8'h10);
		lvl <= 8'h05;
		flush <= 1'b1;
		@(negedge ref_clk);
		chk("flush req", mreq, 1);
		chk("cache cmd", ccmd, 0);
		chk("burst len", blen, 8'h05);
		lvl <= 8'h00;
		flush <= 1'b0;
		acc(1, 1, 8'h84, 8'h00, 8'h00);
		$display("test master done");
		for (int i = 0; i < 10 && exp_q.size() != 0; i++) @(negedge ref_clk);
		chk("reads left", 8'(exp_q.size()), 8'h00);
		end_sim();
	end
endmodule
`default_nettype wire
